//--- logic/cspt_pkg.sv
// Purpose: shared constants and carriers for the clamp/sample pulse timing
// Assumes: one pixel period equals CSPT_EDGES cycles of mclk
// Notes:   register offsets and field positions live here only
package cspt_pkg;

	// ****************************************************************
	// timing grid
	// ****************************************************************
	localparam int unsigned CSPT_EDGES    = 64;  // edges per pixel
	localparam int unsigned CSPT_PHASE_W  = 6;   // bits of edge index
	localparam logic [5:0]  CSPT_LAST_EDGE = 6'h3f;
	localparam logic [5:0]  CSPT_FIRST_EDGE = 6'h00;
	localparam int unsigned CSPT_BIT_LSB  = 3;   // 8 mclk per bit clock
	localparam int unsigned CSPT_BIT_MSB  = 5;
	localparam int unsigned CSPT_BCLK_BIT = 2;   // half bit period
	localparam logic [2:0]  CSPT_FRAME_ODD  = 3'h3; // bit periods high
	localparam logic [2:0]  CSPT_FRAME_EVEN = 3'h2;
	localparam int unsigned CSPT_MCLK_PER_BIT = 8;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] CSPT_OFS_MAIN    = 8'h00;
	localparam logic [7:0] CSPT_OFS_HOLD    = 8'h06;
	localparam logic [7:0] CSPT_OFS_MONITOR = 8'h09;
	localparam logic [7:0] CSPT_OFS_CLP_BEG = 8'h20;
	localparam logic [7:0] CSPT_OFS_CLP_FIN = 8'h21;
	localparam logic [7:0] CSPT_OFS_SMP_BEG = 8'h22;
	localparam logic [7:0] CSPT_OFS_SMP_FIN = 8'h23;
	localparam logic [7:0] CSPT_OFS_STATUS  = 8'h3f;

	// ****************************************************************
	// fields and reset values
	// ****************************************************************
	localparam int unsigned CSPT_CDS_EN_BIT  = 0;  // main configuration
	localparam int unsigned CSPT_HOLD_EN_BIT = 7;  // hold mode control
	localparam int unsigned CSPT_MON_LSB     = 3;  // monitor select
	localparam int unsigned CSPT_MON_MSB     = 4;
	localparam logic [1:0]  CSPT_MON_PULSES  = 2'h2;
	localparam logic [7:0]  CSPT_RST_MAIN    = 8'h00;
	localparam logic [7:0]  CSPT_RST_HOLD    = 8'h80; // hold mode on
	localparam logic [7:0]  CSPT_RST_MONITOR = 8'h00;
	localparam logic [5:0]  CSPT_RST_POS     = 6'h00;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic       correlated_double_sampling;          // correlated double sampling active
		logic       mon_on;       // pulses routed to monitor pins
		logic [5:0] clamp_begin;
		logic [5:0] clamp_finish;
		logic [5:0] sample_begin;
		logic [5:0] sample_finish;
	} cspt_cfg_t;

	typedef struct packed {
		logic wr;                 // one-cycle write strobe
		logic [7:0] addr;
		logic [7:0] wdata;
	} cspt_wr_t;

endpackage

//--- logic/cspt_edge_window.sv
// Purpose: one pulse window over the 64 edge positions of a pixel
// Assumes: phase advances by one edge per mclk
// Notes:   begin above finish wraps into the following period
`timescale 1ns/1ps
module cspt_edge_window (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [5:0] phase,        // current edge index
	input  wire logic [5:0] begin_pos,    // first edge of the pulse
	input  wire logic [5:0] finish_pos,   // edge where the pulse ends
	input  wire logic       enable,       // window allowed at all
	output logic            active        // registered pulse
);

	logic next_active;  // window value for the edge now seen

	// plain case covers [begin, finish); wrap case splits it in two
	always_comb begin
		next_active = 1'b0;
		if (begin_pos <= finish_pos) begin
			next_active = (phase >= begin_pos) && (phase < finish_pos);
		end else begin
			// ends in the next period
			next_active = (phase >= begin_pos) || (phase < finish_pos);
		end
		if (!enable) begin
			next_active = 1'b0;
		end
	end

	// register so every consumer sees a glitch-free pulse
	always_ff @(posedge mclk) begin
		if (reset) begin
			active <= 1'b0;
		end else begin
			active <= next_active;
		end
	end

endmodule

//--- logic/cspt_frame_gen.sv
// Purpose: output bit clock and pixel frame flag
// Assumes: eight mclk cycles per output bit clock period
// Notes:   flag length marks the sampling path of the pixel
`timescale 1ns/1ps
module cspt_frame_gen (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [5:0] phase,            // current edge index
	input  wire logic       correlated_double_sampling,              // double sampling mode
	input  wire logic       odd,              // pixel on odd path
	output logic            output_bit_clock, // registered
	output logic            pixel_frame_flag  // registered
);

	logic [2:0] frame_len;      // bit periods the flag stays high
	logic       next_flag;
	logic       next_bclk;

	// odd pixels and every hold-mode pixel get three periods
	always_comb begin
		if (correlated_double_sampling && !odd) begin
			frame_len = cspt_pkg::CSPT_FRAME_EVEN;
		end else begin
			frame_len = cspt_pkg::CSPT_FRAME_ODD;
		end
		next_flag = phase[cspt_pkg::CSPT_BIT_MSB:cspt_pkg::CSPT_BIT_LSB]
			< frame_len;
		next_bclk = !phase[cspt_pkg::CSPT_BCLK_BIT];
	end

	// both outputs come from flops
	always_ff @(posedge mclk) begin
		if (reset) begin
			pixel_frame_flag <= 1'b0;
			output_bit_clock <= 1'b0;
		end else begin
			pixel_frame_flag <= next_flag;
			output_bit_clock <= next_bclk;
		end
	end

endmodule

//--- logic/cspt_top.sv
// Purpose: clamp and sample pulse timing for a dual channel front end
// Assumes: mclk is the 64x edge clock, 250 MHz; one pixel is 64 mclk
// Notes:   register port is a plain write strobe plus a read address
//
// Notes on behaviour
// - two modes: hold or double sampling
// - hold mode ignores both clamp position registers
// - pixel period split into 64 edges
// - monitor select 10 shows clamp, sample pulses
// - hold sample begin above end wraps over
// - early sample lands in period after clamp
// - double sampling: clamp tracks reference, sample tracks video; hold mode: sample tracks both
// - double sampling alternates even and odd paths
// - frame flag three odd, two even periods
// - hold mode: one path, flag always three
// - one position set serves both paths
// - double sampling monitor shows only odd path pulses
// - gated clamp is clamp AND external input; hold mode passes the input alone
`timescale 1ns/1ps
module cspt_top (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       reg_wr,               // write strobe
	input  wire logic [7:0] reg_addr,             // register offset
	input  wire logic [7:0] reg_wdata,            // write data
	input  wire logic       external_clamp_input, // pin, asynchronous
	output logic [7:0]      reg_rdata,            // data at reg_addr
	output logic            ref_track,            // reference sampler
	output logic            video_track,          // video sampler
	output logic            path_odd,             // odd path in use
	output logic            gated_clamp,          // clamp switch drive
	output logic            monitor_pin_0,
	output logic            monitor_pin_1,
	output logic            output_bit_clock,
	output logic            pixel_frame_flag
);

	// ****************************************************************
	// register file
	// ****************************************************************
	cspt_pkg::cspt_wr_t  wr_req;         // bundled write request
	cspt_pkg::cspt_cfg_t cfg;            // decoded configuration
	logic [7:0] main_configuration;
	logic [7:0] hold_mode_control;
	logic [7:0] pulse_monitor_select;
	logic [5:0] clamp_begin_position;    // upper bits read as zero
	logic [5:0] clamp_finish_position;
	logic [5:0] sample_begin_position;
	logic [5:0] sample_finish_position;
	logic [7:0] next_main;
	logic [7:0] next_hold;
	logic [7:0] next_monitor;
	logic [5:0] next_clp_beg;
	logic [5:0] next_clp_fin;
	logic [5:0] next_smp_beg;
	logic [5:0] next_smp_fin;
	logic [7:0] next_rdata;
	// the status read below needs odd, so it and phase are declared up here
	logic [5:0] phase;        // edge index inside the pixel
	logic       odd;          // pixel now in progress is odd path

	assign wr_req = '{wr: reg_wr, addr: reg_addr, wdata: reg_wdata};

	// write decode; position registers keep only the edge index
	always_comb begin
		next_main    = main_configuration;
		next_hold    = hold_mode_control;
		next_monitor = pulse_monitor_select;
		next_clp_beg = clamp_begin_position;
		next_clp_fin = clamp_finish_position;
		next_smp_beg = sample_begin_position;
		next_smp_fin = sample_finish_position;
		if (wr_req.wr) begin
			unique case (wr_req.addr)
				cspt_pkg::CSPT_OFS_MAIN:    next_main    = wr_req.wdata;
				cspt_pkg::CSPT_OFS_HOLD:    next_hold    = wr_req.wdata;
				cspt_pkg::CSPT_OFS_MONITOR: next_monitor = wr_req.wdata;
				cspt_pkg::CSPT_OFS_CLP_BEG: next_clp_beg = wr_req.wdata[5:0];
				cspt_pkg::CSPT_OFS_CLP_FIN: next_clp_fin = wr_req.wdata[5:0];
				cspt_pkg::CSPT_OFS_SMP_BEG: next_smp_beg = wr_req.wdata[5:0];
				cspt_pkg::CSPT_OFS_SMP_FIN: next_smp_fin = wr_req.wdata[5:0];
				default: begin
					// unmapped offsets are ignored
				end
			endcase
		end
	end

	// read mux; status shows the live path and mode
	always_comb begin
		unique case (reg_addr)
			cspt_pkg::CSPT_OFS_MAIN:    next_rdata = main_configuration;
			cspt_pkg::CSPT_OFS_HOLD:    next_rdata = hold_mode_control;
			cspt_pkg::CSPT_OFS_MONITOR: next_rdata = pulse_monitor_select;
			cspt_pkg::CSPT_OFS_CLP_BEG: next_rdata = {2'h0, clamp_begin_position};
			cspt_pkg::CSPT_OFS_CLP_FIN: next_rdata = {2'h0, clamp_finish_position};
			cspt_pkg::CSPT_OFS_SMP_BEG: next_rdata = {2'h0, sample_begin_position};
			cspt_pkg::CSPT_OFS_SMP_FIN: next_rdata = {2'h0, sample_finish_position};
			cspt_pkg::CSPT_OFS_STATUS:  next_rdata = {6'h00, cfg.correlated_double_sampling, odd};
			default:                    next_rdata = 8'h00;
		endcase
	end

	// register storage, baseline selects hold mode
	always_ff @(posedge mclk) begin
		if (reset) begin
			main_configuration     <= cspt_pkg::CSPT_RST_MAIN;
			hold_mode_control      <= cspt_pkg::CSPT_RST_HOLD;
			pulse_monitor_select   <= cspt_pkg::CSPT_RST_MONITOR;
			clamp_begin_position   <= cspt_pkg::CSPT_RST_POS;
			clamp_finish_position  <= cspt_pkg::CSPT_RST_POS;
			sample_begin_position  <= cspt_pkg::CSPT_RST_POS;
			sample_finish_position <= cspt_pkg::CSPT_RST_POS;
			reg_rdata              <= 8'h00;
		end else begin
			main_configuration     <= next_main;
			hold_mode_control      <= next_hold;
			pulse_monitor_select   <= next_monitor;
			clamp_begin_position   <= next_clp_beg;
			clamp_finish_position  <= next_clp_fin;
			sample_begin_position  <= next_smp_beg;
			sample_finish_position <= next_smp_fin;
			reg_rdata              <= next_rdata;
		end
	end

	// cds needs the hold bit clear as well, so a host that sets cds
	// before clearing hold stays in hold mode until both are done
	always_comb begin
		cfg.correlated_double_sampling = main_configuration[cspt_pkg::CSPT_CDS_EN_BIT]
			&& !hold_mode_control[cspt_pkg::CSPT_HOLD_EN_BIT];
		cfg.mon_on = pulse_monitor_select[cspt_pkg::CSPT_MON_MSB:
			cspt_pkg::CSPT_MON_LSB] == cspt_pkg::CSPT_MON_PULSES;
		cfg.clamp_begin   = clamp_begin_position;
		cfg.clamp_finish  = clamp_finish_position;
		cfg.sample_begin  = sample_begin_position;
		cfg.sample_finish = sample_finish_position;
	end

	// ****************************************************************
	// edge grid and sampling path
	// ****************************************************************
	logic [5:0] next_phase;
	logic       next_odd;

	// path toggles once per pixel; hold mode keeps a single path
	always_comb begin
		next_phase = 6'(phase + 6'h01);
		next_odd   = odd;
		if (!cfg.correlated_double_sampling) begin
			next_odd = 1'b0;
		end else if (phase == cspt_pkg::CSPT_LAST_EDGE) begin
			next_odd = !odd;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			phase <= cspt_pkg::CSPT_FIRST_EDGE;
			odd   <= 1'b0;
		end else begin
			phase <= next_phase;
			odd   <= next_odd;
		end
	end

	// ****************************************************************
	// pulse windows
	// ****************************************************************
	logic clamp_q;    // clamp window, one cycle behind phase
	logic sample_q;   // sample window, one cycle behind phase
	logic odd_q;      // path aligned with the windows
	logic late_q;     // sample belongs to the pixel before

	// one shared position set feeds both paths
	cspt_edge_window u_clamp (
		.mclk       (mclk),
		.reset      (reset),
		.phase      (phase),
		.begin_pos  (cfg.clamp_begin),
		.finish_pos (cfg.clamp_finish),
		.enable     (cfg.correlated_double_sampling),
		.active     (clamp_q)
	);

	cspt_edge_window u_sample (
		.mclk       (mclk),
		.reset      (reset),
		.phase      (phase),
		.begin_pos  (cfg.sample_begin),
		.finish_pos (cfg.sample_finish),
		.enable     (1'b1),
		.active     (sample_q)
	);

	// an early sample pairs with the previous clamp
	always_ff @(posedge mclk) begin
		if (reset) begin
			odd_q  <= 1'b0;
			late_q <= 1'b0;
		end else begin
			odd_q  <= odd;
			late_q <= cfg.correlated_double_sampling
				&& (cfg.sample_begin < cfg.clamp_begin)
				&& (cfg.sample_finish < cfg.clamp_finish);
		end
	end

	// ****************************************************************
	// sampler drive, monitor and clamp gating
	// ****************************************************************
	logic clamp_in_s1;       // first synchroniser stage only
	logic clamp_in_s2;       // safe copy of the external clamp
	logic sample_odd;        // sample pulse that belongs to odd path
	logic next_ref;
	logic next_video;
	logic next_path;
	logic next_gated;
	logic next_mon0;
	logic next_mon1;

	always_comb begin
		sample_odd = sample_q && (late_q ? !odd_q : odd_q);
		if (cfg.correlated_double_sampling) begin
			next_ref   = clamp_q;
			next_gated = clamp_q && clamp_in_s2;
		end else begin
			// hold mode: both inputs sampled on the sample pulse
			next_ref   = sample_q;
			next_gated = clamp_in_s2;
		end
		next_video = sample_q;
		next_path  = late_q ? !odd_q : odd_q;
		next_mon0  = 1'b0;
		next_mon1  = 1'b0;
		if (cfg.mon_on) begin
			if (cfg.correlated_double_sampling) begin
				next_mon0 = clamp_q && odd_q;
				next_mon1 = sample_odd;
			end else begin
				next_mon0 = clamp_q;
				next_mon1 = sample_q;
			end
		end
	end

	// pin inputs pass two flops; all outputs leave from flops
	always_ff @(posedge mclk) begin
		if (reset) begin
			clamp_in_s1   <= 1'b0;
			clamp_in_s2   <= 1'b0;
			ref_track     <= 1'b0;
			video_track   <= 1'b0;
			path_odd      <= 1'b0;
			gated_clamp   <= 1'b0;
			monitor_pin_0 <= 1'b0;
			monitor_pin_1 <= 1'b0;
		end else begin
			clamp_in_s1   <= external_clamp_input;
			clamp_in_s2   <= clamp_in_s1;
			ref_track     <= next_ref;
			video_track   <= next_video;
			path_odd      <= next_path;
			gated_clamp   <= next_gated;
			monitor_pin_0 <= next_mon0;
			monitor_pin_1 <= next_mon1;
		end
	end

	// ****************************************************************
	// output framing
	// ****************************************************************
	cspt_frame_gen u_frame (
		.mclk             (mclk),
		.reset            (reset),
		.phase            (phase),
		.correlated_double_sampling              (cfg.correlated_double_sampling),
		.odd              (odd),
		.output_bit_clock (output_bit_clock),
		.pixel_frame_flag (pixel_frame_flag)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	logic [5:0] frame_run;   // cycles the frame flag has stayed high

	always_ff @(posedge mclk) begin
		if (reset) begin
			frame_run <= 6'h00;
		end else if (pixel_frame_flag) begin
			frame_run <= 6'(frame_run + 6'h01);
		end else begin
			frame_run <= 6'h00;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_phase_wrap: assert property (
		phase == cspt_pkg::CSPT_LAST_EDGE |=> phase == 6'h00 ##63
		phase == cspt_pkg::CSPT_LAST_EDGE)
		else $error("edge grid is not 64 long");

	a_path_alt: assert property (
		cfg.correlated_double_sampling && phase == cspt_pkg::CSPT_LAST_EDGE ##1 cfg.correlated_double_sampling
		|-> odd != $past(odd))
		else $error("path did not alternate");

	a_hold_single: assert property (
		!cfg.correlated_double_sampling |=> !odd)
		else $error("hold mode left the single path");

	a_mon_idle: assert property (
		!cfg.mon_on |=> !monitor_pin_0 && !monitor_pin_1)
		else $error("monitor pins active while unselected");

	a_mon_odd: assert property (
		cfg.correlated_double_sampling && cfg.mon_on && clamp_q && !odd_q
		|=> !monitor_pin_0)
		else $error("even clamp shown on monitor");

	a_gate_and: assert property (
		gated_clamp && $past(cfg.correlated_double_sampling)
		|-> $past(clamp_q) && $past(clamp_in_s2))
		else $error("gated clamp without both terms");

	a_hold_clamp: assert property (
		!cfg.correlated_double_sampling ##1 !cfg.correlated_double_sampling |-> !clamp_q)
		else $error("clamp window active in hold mode");

	a_frame_hold: assert property (
		$fell(pixel_frame_flag) && !cfg.correlated_double_sampling && !$past(cfg.correlated_double_sampling, 2)
		|-> $past(frame_run) == 6'd23)
		else $error("hold mode frame flag not three bit periods");

	a_frame_cds: assert property (
		$fell(pixel_frame_flag) && cfg.correlated_double_sampling && $past(cfg.correlated_double_sampling, 2)
		|-> $past(frame_run) == 6'd23 || $past(frame_run) == 6'd15)
		else $error("cds frame flag length wrong");

	a_wrap_sample: assert property (
		cfg.sample_begin > cfg.sample_finish && cfg.sample_finish != 6'h00
		&& $stable(cfg.sample_begin) && $stable(cfg.sample_finish)
		&& phase == 6'h00 |=> sample_q)
		else $error("wrapped sample missing at period start");

	c_cds_mon: cover property (cfg.correlated_double_sampling && monitor_pin_1);
	c_late: cover property (late_q && sample_odd);
	c_even_frame: cover property ($fell(pixel_frame_flag)
		&& $past(frame_run) == 6'd15);
	c_gated: cover property (gated_clamp && cfg.correlated_double_sampling);

endmodule

//--- tb/cspt_sensor_model.sv
// Purpose: sensor side drive of the external clamp pin
// Assumes: the bench picks the pattern for each scenario
// Notes:   the pin only changes just after an mclk edge
`timescale 1ns/1ps
module cspt_sensor_model (
	input  wire logic       mclk,
	input  wire logic [1:0] clamp_mode,          // 0 low, 1 high, 2 toggle
	output logic            external_clamp_input // clamp request pin
);
	// a toggling pin shows that hold mode passes the input alone to the gate
	initial external_clamp_input = 1'b0;
	// pattern register, updated once per edge
	always @(posedge mclk) begin
		case (clamp_mode)
		2'h1: external_clamp_input <= 1'b1;
		2'h2: external_clamp_input <= ~external_clamp_input;
		default: external_clamp_input <= 1'b0;
		endcase
	end
endmodule

//--- tb/cspt_top_tb.sv
// Purpose: self-checking bench for the clamp/sample pulse timing
// Assumes: counts are taken over four whole pixels after settling
// Notes:   window widths give counts that do not depend on phase
`timescale 1ns/1ps
module cspt_top_tb;
	logic       mclk;       // 4 ns edge clock
	logic       reset;      // synchronous, active high
	logic       reg_wr;     // write strobe
	logic [7:0] reg_addr;   // register offset
	logic [7:0] reg_wdata;  // write data
	logic [1:0] clamp_mode; // sensor clamp pattern
	logic       ext_clamp;  // sensor clamp pin
	logic [7:0] reg_rdata;
	logic       ref_track, video_track, path_odd, gated_clamp;
	logic       monitor_pin_0, monitor_pin_1;
	logic       output_bit_clock, pixel_frame_flag;
	integer     failures, checked;
	integer     n_vid, n_ref, n_m0, n_m1, n_gate, n_bclk, n_odd, n_late;
	integer     fmin, fmax;
	logic [7:0] ofs [8]  = '{8'h00, 8'h06, 8'h09, 8'h20,
		8'h21, 8'h22, 8'h23, 8'h10};
	logic [7:0] rstv [8] = '{8'h00, 8'h80, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00};

	cspt_top i_cspt_top (
		.mclk                 (mclk),
		.reset                (reset),
		.reg_wr               (reg_wr),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.external_clamp_input (ext_clamp),
		.reg_rdata            (reg_rdata),
		.ref_track            (ref_track),
		.video_track          (video_track),
		.path_odd             (path_odd),
		.gated_clamp          (gated_clamp),
		.monitor_pin_0        (monitor_pin_0),
		.monitor_pin_1        (monitor_pin_1),
		.output_bit_clock     (output_bit_clock),
		.pixel_frame_flag     (pixel_frame_flag)
	);

	cspt_sensor_model i_cspt_sensor_model (
		.mclk                 (mclk),
		.clamp_mode           (clamp_mode),
		.external_clamp_input (ext_clamp)
	);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// clock: 250 MHz
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// compare and count; a four-state mismatch never passes
	task check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("unexpected %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// single write, strobe high for exactly one edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask

	// read: data is registered one cycle after the address
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		@(posedge mclk);
		@(negedge mclk);
		check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
	endtask

	// settle 128 cycles, then count highs over four pixels; frame runs
	// are tracked from the start so the last finished run is known
	task measure;
		integer i, run, last;
		logic   prev;
		n_vid = 0; n_ref = 0; n_m0 = 0; n_m1 = 0;
		n_gate = 0; n_bclk = 0; n_odd = 0; n_late = 0;
		fmin = 999; fmax = 0; run = 0; last = 0;
		prev = pixel_frame_flag;
		for (i = 0; i < 384; i++) begin
			@(negedge mclk);
			// only runs seen from their rising edge are measured
			if (pixel_frame_flag) begin
				if (!prev) run = 1;
				else if (run > 0) run = run + 1;
			end else if (prev && run > 0) begin
				if (i >= 128 && run < fmin) fmin = run;
				if (i >= 128 && run > fmax) fmax = run;
				last = run;
			end
			prev = pixel_frame_flag;
			if (i >= 128) begin
				n_vid  += video_track;   n_ref += ref_track;
				n_m0   += monitor_pin_0; n_m1  += monitor_pin_1;
				n_gate += gated_clamp;   n_odd += path_odd;
				n_bclk += output_bit_clock;
				// monitored sample seen after an odd-length frame
				n_late += monitor_pin_1 && last == 24;
			end
		end
	endtask

	// the expected counts of one scenario
	task expect_all(input int v, r, m0, m1, g, fmn, fmx, od);
		check("video_track", n_vid, v);
		check("ref_track", n_ref, r);
		check("monitor_pin_0", n_m0, m0);
		check("monitor_pin_1", n_m1, m1);
		check("gated_clamp", n_gate, g);
		check("frame_min", fmin, fmn);
		check("frame_max", fmax, fmx);
		check("path_odd", n_odd, od);
		check("output_bit_clock", n_bclk, 128);
	endtask

	// verdict, the single end of the run
	task complete_run;
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// watchdog: the tests need well under 5000 cycles
	initial begin
		#100000;
		failures = failures + 1;
		complete_run();
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		failures = 0; checked = 0;
		reset = 1'b1; reg_wr = 1'b0; reg_addr = 8'h00;
		reg_wdata = 8'h00; clamp_mode = 2'h0;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		// reset values, unmapped offset reads zero
		for (int k = 0; k < 8; k++) rd(ofs[k], rstv[k]);
		// positions keep only six index bits
		wr(8'h22, 8'hff);
		rd(8'h22, 8'h3f);
		// hold mode, wrapping sample 60..4, clamp values must not count
		wr(8'h20, 8'h0a);
		wr(8'h21, 8'h14);
		wr(8'h22, 8'h3c);
		wr(8'h23, 8'h04);
		wr(8'h09, 8'h10);
		clamp_mode <= 2'h2;
		measure();
		expect_all(32, 32, 0, 32, 128, 24, 24, 0);
		// other monitor select leaves monitor_pin_1 low
		wr(8'h09, 8'h08);
		measure();
		check("monitor_pin_1", n_m1, 0);
		// host order for double sampling: hold bit off, then enable
		wr(8'h06, 8'h00);
		wr(8'h00, 8'h01);
		wr(8'h20, 8'h08);
		wr(8'h21, 8'h14);
		wr(8'h22, 8'h1e);
		wr(8'h23, 8'h32);
		wr(8'h09, 8'h10);
		clamp_mode <= 2'h1;
		measure();
		expect_all(80, 48, 24, 40, 48, 16, 24, 128);
		check("late_pair", n_late, 40);
		rd(8'h06, 8'h00);
		// status bit 1 shows double sampling active
		@(posedge mclk);
		reg_addr <= 8'h3f;
		@(posedge mclk);
		@(negedge mclk);
		check("status_cds", {15'h0000, reg_rdata[1]}, 16'h0001);
		// early sample values land in the following period
		wr(8'h22, 8'h02);
		wr(8'h23, 8'h06);
		clamp_mode <= 2'h0;
		measure();
		expect_all(16, 48, 24, 8, 0, 16, 24, 128);
		check("late_pair", n_late, 8);
		complete_run();
	end
endmodule
